/* File: hdl/ccr_regs.sv */
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module ccr_regs (
  input  wire logic                 aclk,              // Bus clock, 25 MHz
  input  wire logic                 aresetn,           // Synchronous reset
  input  wire logic [7:0]           s_axi_awaddr,      // Write address
  input  wire logic                 s_axi_awvalid,     // Write address valid
  output logic                      s_axi_awready,     // Write address ready
  input  wire logic [31:0]          s_axi_wdata,       // Write data
  input  wire logic [3:0]           s_axi_wstrb,       // Write strobes
  input  wire logic                 s_axi_wvalid,      // Write data valid
  output logic                      s_axi_wready,      // Write data ready
  output logic [1:0]                s_axi_bresp,       // Write response
  output logic                      s_axi_bvalid,      // Write response valid
  input  wire logic                 s_axi_bready,      // Write response ready
  input  wire logic [7:0]           s_axi_araddr,      // Read address
  input  wire logic                 s_axi_arvalid,     // Read address valid
  output logic                      s_axi_arready,     // Read address ready
  output logic [31:0]               s_axi_rdata,       // Read data
  output logic [1:0]                s_axi_rresp,       // Read response
  output logic                      s_axi_rvalid,      // Read data valid
  input  wire logic                 s_axi_rready,      // Read data ready
  input  wire logic                 chop_phase_start,  // Chop phase begins, pulse
  input  wire logic signed [23:0]   conv_data,         // Raw channel result
  input  wire logic                 conv_valid,        // Raw result strobe
  output logic [1:0]                first_input_select,// Input mux code
  output logic                      chop_switch_on,    // Global chop enabled
  output logic                      chop_settling,     // Settle delay running
  output logic                      measure_start,     // Settle done, pulse
  output logic signed [23:0]        corr_data,         // Offset-corrected result
  output logic                      corr_valid         // Corrected result strobe
);

  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic [5:0]           widx;
    logic [15:0]          wd;
    logic [1:0]           ws;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic [15:0]          chop_cfg;
    logic [15:0]          spare_a;
    logic [15:0]          spare_b;
    logic [15:0]          ch_cfg;
    logic [15:0]          ocal_hi;
    logic [15:0]          ocal_lo;
    // Settle sequencer
    ccr_pkg::ccr_seq_t    seq;
    logic [16:0]          dcnt;
    logic [7:0]           tdiv;
    logic                 mod_tick;
    logic                 mstart;
    logic [1:0]           sel;
    logic                 chop_on;
    logic                 settling;
    // Offset datapath
    logic signed [23:0]   corr;
    logic                 corr_valid;
  } ccr_state_t;

  localparam ccr_state_t RST_STATE = '{
    awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: ccr_pkg::RESP_OKAY,
    widx: 6'h00, wd: 16'h0000, ws: 2'h0, arready: 1'b1, rvalid: 1'b0,
    rresp: ccr_pkg::RESP_OKAY, rdata: 32'h00000000,
    chop_cfg: ccr_pkg::RST_CHOP, spare_a: ccr_pkg::RST_ZERO,
    spare_b: ccr_pkg::RST_ZERO, ch_cfg: ccr_pkg::RST_ZERO,
    ocal_hi: ccr_pkg::RST_ZERO, ocal_lo: ccr_pkg::RST_ZERO,
    seq: ccr_pkg::CCR_IDLE, dcnt: 17'h00000, tdiv: 8'h00, mod_tick: 1'b0,
    mstart: 1'b0, sel: 2'h0, chop_on: 1'b0, settling: 1'b0,
    corr: 24'sh000000, corr_valid: 1'b0};

  ccr_state_t s_r;
  ccr_state_t s_nxt;

  // Byte lanes and the fixed-zero bits both gate each write
  function automatic logic [15:0] wr_merge(input logic [15:0] old, input logic [15:0] d,
                                           input logic [1:0] st, input logic [15:0] m);
    logic [15:0] bm;
    bm = {{8{st[1]}}, {8{st[0]}}} & m;
    return (old & ~bm) | (d & bm);
  endfunction

  // Status index is read-only; its writes answer OKAY and change nothing
  function automatic logic mapped(input logic [5:0] idx);
    return idx == ccr_pkg::IDX_CHOP || idx == ccr_pkg::IDX_SPARE_A ||
           idx == ccr_pkg::IDX_SPARE_B || idx == ccr_pkg::IDX_CH_CFG ||
           idx == ccr_pkg::IDX_OCAL_HI || idx == ccr_pkg::IDX_OCAL_LO ||
           idx == ccr_pkg::IDX_STATUS;
  endfunction

  logic [5:0]         ridx;
  logic [15:0]        rval;
  logic signed [23:0] offset;

  always_comb begin
    ridx = s_axi_araddr[ccr_pkg::IDX_MSB:ccr_pkg::IDX_LSB];
    case (ridx)
      ccr_pkg::IDX_CHOP:    rval = s_r.chop_cfg;
      ccr_pkg::IDX_SPARE_A: rval = s_r.spare_a;
      ccr_pkg::IDX_SPARE_B: rval = s_r.spare_b;
      ccr_pkg::IDX_CH_CFG:  rval = s_r.ch_cfg;
      ccr_pkg::IDX_OCAL_HI: rval = s_r.ocal_hi;
      ccr_pkg::IDX_OCAL_LO: rval = s_r.ocal_lo;
      ccr_pkg::IDX_STATUS: begin
        rval = ccr_pkg::RST_ZERO;
        rval[ccr_pkg::STAT_SETTLE] = s_r.settling;
        rval[ccr_pkg::STAT_EN] = s_r.chop_on;
      end
      default:              rval = ccr_pkg::RST_ZERO;
    endcase
  end

  // Upper register then upper byte of the lower one, taken as signed
  assign offset = {s_r.ocal_hi, s_r.ocal_lo[ccr_pkg::OLO_MSB:ccr_pkg::OLO_LSB]};

  always_comb begin
    s_nxt = s_r;
    s_nxt.mod_tick = 1'b0;
    s_nxt.mstart = 1'b0;
    s_nxt.corr_valid = 1'b0;

    // Write address and data are taken in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.awready = 1'b0;
      s_nxt.widx = s_axi_awaddr[ccr_pkg::IDX_MSB:ccr_pkg::IDX_LSB];
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.wready = 1'b0;
      s_nxt.wd = s_axi_wdata[15:0];
      s_nxt.ws = s_axi_wstrb[1:0];
    end
    if (!s_r.awready && !s_r.wready && !s_r.bvalid) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = mapped(s_r.widx) ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
      case (s_r.widx)
        ccr_pkg::IDX_CHOP:
          s_nxt.chop_cfg = wr_merge(s_r.chop_cfg, s_r.wd, s_r.ws, ccr_pkg::MASK_CHOP);
        ccr_pkg::IDX_SPARE_A:
          s_nxt.spare_a = wr_merge(s_r.spare_a, s_r.wd, s_r.ws, ccr_pkg::MASK_SPARE_A);
        ccr_pkg::IDX_SPARE_B:
          s_nxt.spare_b = wr_merge(s_r.spare_b, s_r.wd, s_r.ws, ccr_pkg::MASK_SPARE_B);
        ccr_pkg::IDX_CH_CFG:
          s_nxt.ch_cfg = wr_merge(s_r.ch_cfg, s_r.wd, s_r.ws, ccr_pkg::MASK_CH_CFG);
        ccr_pkg::IDX_OCAL_HI:
          s_nxt.ocal_hi = wr_merge(s_r.ocal_hi, s_r.wd, s_r.ws, ccr_pkg::MASK_OCAL_HI);
        ccr_pkg::IDX_OCAL_LO:
          s_nxt.ocal_lo = wr_merge(s_r.ocal_lo, s_r.wd, s_r.ws, ccr_pkg::MASK_OCAL_LO);
        default: ;
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end

    // One read in flight; address is refused until the data is taken
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = {16'h0000, rval};
      s_nxt.rresp = mapped(ridx) ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // Modulator period enable
    if (s_r.tdiv == ccr_pkg::MOD_DIV_LAST) begin
      s_nxt.tdiv = 8'h00;
      s_nxt.mod_tick = 1'b1;
    end else begin
      s_nxt.tdiv = s_r.tdiv + 8'h01;
    end

    // Settle delay; dropping the enable aborts it
    case (s_r.seq)
      ccr_pkg::CCR_IDLE: begin
        if (chop_phase_start && s_r.chop_cfg[ccr_pkg::EN_BIT]) begin
          s_nxt.seq = ccr_pkg::CCR_WAIT;
          s_nxt.dcnt = ccr_pkg::DLY_W'(ccr_pkg::DLY_BASE <<
                       s_r.chop_cfg[ccr_pkg::DLY_MSB:ccr_pkg::DLY_LSB]);
        end
      end
      ccr_pkg::CCR_WAIT: begin
        if (!s_r.chop_cfg[ccr_pkg::EN_BIT]) begin
          s_nxt.seq = ccr_pkg::CCR_IDLE;
        end else if (s_r.mod_tick) begin
          if (s_r.dcnt == ccr_pkg::DLY_ONE) begin
            s_nxt.seq = ccr_pkg::CCR_IDLE;
            s_nxt.mstart = 1'b1;
          end else begin
            s_nxt.dcnt = s_r.dcnt - ccr_pkg::DLY_ONE;
          end
        end
      end
      default: s_nxt.seq = ccr_pkg::CCR_IDLE;
    endcase
    s_nxt.settling = s_nxt.seq == ccr_pkg::CCR_WAIT;

    // Select registered from the next value so the mux never sees a stale code
    s_nxt.sel = s_nxt.ch_cfg[ccr_pkg::SEL_MSB:ccr_pkg::SEL_LSB];
    s_nxt.chop_on = s_nxt.chop_cfg[ccr_pkg::EN_BIT];

    // Wraps on overflow, as the raw datapath does
    if (conv_valid) begin
      s_nxt.corr = conv_data - offset;
      s_nxt.corr_valid = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready      = s_r.awready;
  assign s_axi_wready       = s_r.wready;
  assign s_axi_bvalid       = s_r.bvalid;
  assign s_axi_bresp        = s_r.bresp;
  assign s_axi_arready      = s_r.arready;
  assign s_axi_rvalid       = s_r.rvalid;
  assign s_axi_rresp        = s_r.rresp;
  assign s_axi_rdata        = s_r.rdata;
  assign first_input_select = s_r.sel;
  assign chop_switch_on     = s_r.chop_on;
  assign chop_settling      = s_r.settling;
  assign measure_start      = s_r.mstart;
  assign corr_data          = s_r.corr;
  assign corr_valid         = s_r.corr_valid;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lo_byte_zero: assert property (s_r.ocal_lo[7:0] == 8'h00)
    else $error("Lower offset low byte not zero");
  a_cfg_ro_bits: assert property (s_r.ch_cfg[5:3] == 3'h0)
    else $error("Channel config bits 5:3 not zero");
  a_spare_ro_nib: assert property (s_r.spare_b[7:4] == 4'h0)
    else $error("Spare register bits 7:4 not zero");
  a_sel_follows: assert property ($rose(s_r.bvalid) && s_r.widx == ccr_pkg::IDX_CH_CFG
                                  && s_r.ws[0] |-> first_input_select == s_r.wd[1:0])
    else $error("Input select did not follow write");
  a_start_needs_en: assert property (measure_start |-> $past(s_r.chop_cfg[8], 2))
    else $error("Measurement started with chop disabled");
  a_delay_short: assert property (s_r.seq == ccr_pkg::CCR_IDLE && chop_phase_start &&
                                  s_r.chop_cfg[12:8] == 5'h01
                                  |=> !measure_start [*4] ##[1:6] measure_start)
    else $error("Shortest chop delay wrong length");
  a_corr_value: assert property (conv_valid |=> corr_valid &&
                                 corr_data == 24'($past(conv_data) - $past(offset)))
    else $error("Corrected result wrong");
  a_bresp_map: assert property ($rose(s_axi_bvalid) |->
                                (s_axi_bresp == ccr_pkg::RESP_SLVERR) == !mapped(s_r.widx))
    else $error("Write response does not match decode");
  a_chop_reset: assert property (disable iff (1'b0) !aresetn |=> s_r.chop_cfg == 16'h0600)
    else $error("Chop register reset value wrong");
  a_hi_write: assert property ($rose(s_r.bvalid) && s_r.widx == ccr_pkg::IDX_OCAL_HI &&
                               s_r.ws == 2'h3 |-> offset[23:8] == s_r.wd)
    else $error("Upper offset not stored");

  // Abort must leave no stray start pulse behind
  a_meas_pulse: assert property (measure_start |-> !chop_settling ##1 !measure_start)
    else $error("Measurement start not a single pulse");
  a_settle_entry: assert property (s_r.seq == ccr_pkg::CCR_IDLE && chop_phase_start &&
                                   s_r.chop_cfg[ccr_pkg::EN_BIT] |=> chop_settling)
    else $error("Settle delay did not start");
  a_abort_quiet: assert property ($fell(s_r.chop_cfg[ccr_pkg::EN_BIT]) |=>
                                  !measure_start && !chop_settling)
    else $error("Settle delay survived chop disable");
  a_sel_reset: assert property (disable iff (1'b0) !aresetn |=>
                                first_input_select == 2'h0 && s_r.ch_cfg == ccr_pkg::RST_ZERO)
    else $error("Channel config reset value wrong");

  // Readies must come back or the next transfer stalls for good
  a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=>
                                 s_axi_awready && s_axi_wready && !s_axi_bvalid)
    else $error("Write readies not restored after response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
                                  s_axi_rvalid && !s_axi_arready)
    else $error("Read not answered in the next cycle");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("Read data upper half not zero");
  a_status_ro: assert property ($rose(s_r.bvalid) && s_r.widx == ccr_pkg::IDX_STATUS |->
                                $stable(s_r.chop_cfg))
    else $error("Status write changed chop register");
endmodule

/* File: inc/ccr_pkg.sv */
package ccr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0]  IDX_CHOP     = 6'h06;
  localparam logic [5:0]  IDX_SPARE_A  = 6'h07;
  localparam logic [5:0]  IDX_SPARE_B  = 6'h08;
  localparam logic [5:0]  IDX_CH_CFG   = 6'h09;
  localparam logic [5:0]  IDX_OCAL_HI  = 6'h0A;
  localparam logic [5:0]  IDX_OCAL_LO  = 6'h0B;
  localparam logic [5:0]  IDX_STATUS   = 6'h1F;
  localparam int          ADDR_W       = 8;
  localparam int          IDX_LSB      = 2;
  localparam int          IDX_MSB      = 7;

  // Writable bit masks
  localparam logic [15:0] MASK_CHOP    = 16'hFFFF;
  localparam logic [15:0] MASK_SPARE_A = 16'hFFFF;
  localparam logic [15:0] MASK_SPARE_B = 16'hFF0F;
  localparam logic [15:0] MASK_CH_CFG  = 16'hFFC7;
  localparam logic [15:0] MASK_OCAL_HI = 16'hFFFF;
  localparam logic [15:0] MASK_OCAL_LO = 16'hFF00;

  localparam logic [15:0] RST_CHOP     = 16'h0600;
  localparam logic [15:0] RST_ZERO     = 16'h0000;

  // Field positions
  localparam int          DLY_MSB      = 12;
  localparam int          DLY_LSB      = 9;
  localparam int          EN_BIT       = 8;
  localparam int          SEL_MSB      = 1;
  localparam int          SEL_LSB      = 0;
  localparam int          OLO_MSB      = 15;
  localparam int          OLO_LSB      = 8;
  localparam int          STAT_SETTLE  = 0;
  localparam int          STAT_EN      = 1;

  // Delay length: 2 modulator periods shifted left by the code
  localparam int          DLY_W        = 17;
  localparam logic [16:0] DLY_BASE     = 17'h00002;
  localparam logic [16:0] DLY_ONE      = 17'h00001;

  // Modulator clock as an enable pulse derived from the bus clock
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          MOD_PERIOD_NS = 160;
  localparam int          MOD_DIV       = (MOD_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                          MOD_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  MOD_DIV_LAST  = 8'(MOD_DIV - 1);

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [0:0] {
    CCR_IDLE = 1'b0,
    CCR_WAIT = 1'b1
  } ccr_seq_t;
endpackage

/* File: verification/ccr_regs_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module ccr_regs_tb;
  logic               aclk;
  logic               aresetn;
  logic [7:0]         awaddr;
  logic [7:0]         araddr;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp, sel;
  logic               phase_start, conv_valid, chop_on, settling, meas, corr_valid;
  logic signed [23:0] conv_data, corr_data;
  int                 err_count;
  int                 total_checks;
  logic [5:0]         ix [5];
  logic [15:0]        rb [5];
  logic [15:0]        wv [5];

  ccr_regs DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chop_phase_start(phase_start), .conv_data(conv_data), .conv_valid(conv_valid),
    .first_input_select(sel), .chop_switch_on(chop_on), .chop_settling(settling),
    .measure_start(meas), .corr_data(corr_data), .corr_valid(corr_valid)
  );

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Both channels offered together; each released at its own take
  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= {idx, 2'h0};
    wdata   <= {16'h0000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid === 1'h1 && bready) && n < 50);
    if (bvalid !== 1'h1) begin
      err_count++;
      results();
    end
    bready <= 1'h0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [15:0] e, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready  <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid === 1'h1 && rready) && n < 50);
    if (rvalid !== 1'h1) begin
      err_count++;
      results();
    end
    rready <= 1'h0;
    `CHK("rdata", {16'h0000, e}, rdata)
    `CHK("rresp", er, rresp)
  endtask

  task automatic off_case(input logic [15:0] hi, input logic [15:0] lo, input logic [23:0] x);
    logic [23:0] e;
    e = x - {hi, lo[15:8]};
    wr(ccr_pkg::IDX_OCAL_HI, hi, ccr_pkg::RESP_OKAY);
    wr(ccr_pkg::IDX_OCAL_LO, lo, ccr_pkg::RESP_OKAY);
    @(posedge aclk);
    conv_data  <= x;
    conv_valid <= 1'h1;
    @(posedge aclk);
    conv_valid <= 1'h0;
    @(posedge aclk);
    `CHK("corr_valid", 1'h1, corr_valid)
    `CHK("corr_data", e, corr_data)
    @(posedge aclk);
    `CHK("corr_pulse", 1'h0, corr_valid)
  endtask

  // Divider phase is free running, so the first tick may land up to one period early
  task automatic settle(input logic [3:0] code, input bit abort);
    int n;
    int cyc;
    cyc = ccr_pkg::MOD_DIV * (2 << code);
    wr(ccr_pkg::IDX_CHOP, {3'h0, code, 1'h1, 8'h00}, ccr_pkg::RESP_OKAY);
    `CHK("chop_on", 1'h1, chop_on)
    @(posedge aclk);
    phase_start <= 1'h1;
    @(posedge aclk);
    phase_start <= 1'h0;
    @(posedge aclk);
    `CHK("settling", 1'h1, settling)
    n = 1;
    if (abort) begin
      rdc(ccr_pkg::IDX_STATUS, 16'h0003, ccr_pkg::RESP_OKAY);
      wr(ccr_pkg::IDX_CHOP, {3'h0, code, 1'h0, 8'h00}, ccr_pkg::RESP_OKAY);
    end
    while (meas !== 1'h1 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    if (abort) `CHK("no_pulse", 300, n)
    else `CHK("delay_ok", 1'h1, (n >= cyc - 4 && n <= cyc + 2))
  endtask

  initial begin
    err_count    = 0;
    total_checks = 0;
    aresetn      = 1'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {phase_start, conv_valid, conv_data} = '0;
    ix = '{ccr_pkg::IDX_SPARE_A, ccr_pkg::IDX_SPARE_B, ccr_pkg::IDX_CH_CFG,
           ccr_pkg::IDX_OCAL_HI, ccr_pkg::IDX_OCAL_LO};
    // Reserved fields only ever see zeros; read-only bits may be hit with ones
    wv = '{16'h0000, 16'h0000, 16'h003B, 16'hFFFF, 16'hFFFF};
    rb = '{16'h0000, 16'h0000, 16'h0003, 16'hFFFF, 16'hFF00};
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    `CHK("sel_reset", 2'h0, sel)
    `CHK("chop_reset", 1'h0, chop_on)
    rdc(ccr_pkg::IDX_CHOP, 16'h0600, ccr_pkg::RESP_OKAY);
    for (int i = 0; i < 5; i++) rdc(ix[i], 16'h0000, ccr_pkg::RESP_OKAY);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      wr(ix[i], wv[i], ccr_pkg::RESP_OKAY);
      rdc(ix[i], rb[i], ccr_pkg::RESP_OKAY);
      wr(ix[i], 16'h0000, ccr_pkg::RESP_OKAY);
    end
    wr(6'h0C, 16'h1234, ccr_pkg::RESP_SLVERR);
    rdc(6'h0C, 16'h0000, ccr_pkg::RESP_SLVERR);
    wr(ccr_pkg::IDX_STATUS, 16'h0003, ccr_pkg::RESP_OKAY);
    rdc(ccr_pkg::IDX_STATUS, 16'h0000, ccr_pkg::RESP_OKAY);
    $display("test access kinds done");
    for (int i = 0; i < 4; i++) begin
      wr(ccr_pkg::IDX_CH_CFG, 16'(i), ccr_pkg::RESP_OKAY);
      `CHK("input_select", 2'(i), sel)
    end
    $display("test input select done");
    off_case(16'h1234, 16'h5600, 24'h200000);
    off_case(16'hFFFF, 16'hFF00, 24'h000005);
    off_case(16'h8000, 16'h00FF, 24'h7FFFFF);
    $display("test offset done");
    settle(4'h0, 1'b0);
    settle(4'h1, 1'b0);
    settle(4'h4, 1'b0);
    settle(4'h3, 1'b1);
    `CHK("abort_idle", 1'h0, settling)
    $display("test chop delay done");
    results();
  end

  // Longest run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    results();
  end
endmodule
